// File: ccr_core.sv
// Module: CPU core programmer-visible registers and sequencing
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
module ccr_core (
    // Clock and reset
    input  wire logic                 clock_i,
    input  wire logic                 rst_i,
    // Operation request from the decoder
    input  wire logic                 op_valid_i,
    input  wire ccr_pkg::ccr_op_t     op_i,
    input  wire logic [7:0]           operand_i,
    input  wire logic [15:0]          target_i,
    input  wire logic                 fetch_i,
    output logic                      op_ready_o,
    // Memory bus
    output logic [15:0]               mem_addr_o,
    output logic [7:0]                mem_wdata_o,
    output logic                      mem_wr_o,
    output logic                      mem_rd_o,
    input  wire logic [7:0]           mem_rdata_i,
    // Interrupts and options
    input  wire logic [7:0]           irq_req_i,
    input  wire logic                 break_req_i,
    input  wire logic                 break_en_i,
    input  wire logic                 monitor_mode_i,
    input  wire logic                 short_recovery_option_i,
    input  wire logic                 stop_enable_i,
    input  wire logic                 oscillator_ref_clock_i,
    output logic                      cpu_clock_run_o,
    output logic                      in_break_o,
    // Register port
    input  wire logic [2:0]           reg_addr_i,
    input  wire logic [15:0]          reg_wdata_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    output logic [15:0]               reg_rdata_o
);
    import ccr_pkg::*;

    typedef struct packed {
        ccr_state_t  st;
        logic [7:0]  accumulator;
        logic [15:0] index_pair;
        logic [15:0] stack_ptr;
        logic [15:0] prog_counter;
        logic [7:0]  cond_code_reg;
        logic [2:0]  step;
        logic [15:0] vec;
        logic        swi_pend;
        logic        in_break;
        logic [CCR_DLY_W-1:0] dly;
        logic [7:0]  irq_s1;
        logic [7:0]  irq_s2;
        logic [4:0]  misc_s1;
        logic [4:0]  misc_s2;
        logic        osc_prev;
        logic [15:0] rdata;
    } ccr_regs_t;

    ccr_regs_t r;
    ccr_regs_t next_r;

    // Combined result for flag update
    logic [8:0]  sum;
    logic [4:0]  low_sum;
    logic [7:0]  res;
    logic        cin;
    logic        irq_any;
    logic [15:0] irq_vec;
    logic        stop_limit;

    always_comb begin
        next_r = r;
        cin = r.cond_code_reg[CCR_BIT_C];
        sum = 9'h000;
        low_sum = 5'h00;
        res = CCR_ZERO8;
        mem_addr_o = r.stack_ptr;
        mem_wdata_o = CCR_ZERO8;
        mem_wr_o = 1'b0;
        mem_rd_o = 1'b0;
        op_ready_o = 1'b0;
        irq_any = 1'b0;
        irq_vec = CCR_VEC_IRQ_BASE;
        // Lowest index wins: highest priority
        for (int i = CCR_NUM_IRQ - 1; i >= 0; i--) begin
            if (r.irq_s2[i]) begin
                irq_any = 1'b1;
                irq_vec = 16'(CCR_VEC_IRQ_BASE - 16'(i) * CCR_VEC_IRQ_STEP);
            end
        end
        next_r.irq_s1 = irq_req_i;
        next_r.irq_s2 = r.irq_s1;
        next_r.misc_s1 = {oscillator_ref_clock_i, break_req_i, break_en_i,
                          monitor_mode_i, short_recovery_option_i};
        next_r.misc_s2 = r.misc_s1;
        next_r.osc_prev = r.misc_s2[4];
        stop_limit = r.misc_s2[0]
            ? (r.dly == CCR_DLY_W'(CCR_STOP_SHORT_CYC - 1))
            : (r.dly == CCR_DLY_W'(CCR_STOP_LONG_CYC - 1));
        if (r.misc_s2[3] && r.misc_s2[2] && !r.in_break)
            next_r.swi_pend = 1'b1;

        unique case (r.st)
            CCR_ST_VEC_HI: begin
                // Reset and the illegal-stop trap share this fetch
                mem_addr_o = r.vec;
                mem_rd_o = 1'b1;
                next_r.prog_counter[15:8] = mem_rdata_i;
                next_r.st = CCR_ST_VEC_LO;
            end
            CCR_ST_VEC_LO: begin
                mem_addr_o = 16'(r.vec + CCR_ONE16);
                mem_rd_o = 1'b1;
                next_r.prog_counter[7:0] = mem_rdata_i;
                next_r.st = CCR_ST_RUN;
            end
            CCR_ST_RUN: begin
                op_ready_o = 1'b1;
                if (op_valid_i && (r.swi_pend ||
                        (irq_any && !r.cond_code_reg[CCR_BIT_I]))) begin
                    // Taken between instructions
                    op_ready_o = 1'b0;
                    next_r.vec = r.swi_pend ? (r.misc_s2[1] ? CCR_VEC_SWI_MON
                                               : CCR_VEC_SWI) : irq_vec;
                    if (r.swi_pend) begin
                        next_r.in_break = 1'b1;
                        next_r.swi_pend = 1'b0;
                    end
                    next_r.st = CCR_ST_PUSH;
                    next_r.step = 3'h0;
                end else if (op_valid_i) begin
                    if (fetch_i)
                        next_r.prog_counter = 16'(r.prog_counter + CCR_ONE16);
                    unique case (op_i)
                        CCR_OP_ADD, CCR_OP_ADC: begin
                            cin = (op_i == CCR_OP_ADC) && r.cond_code_reg[CCR_BIT_C];
                            sum = {1'b0, r.accumulator} + {1'b0, operand_i} + 9'(cin);
                            low_sum = {1'b0, r.accumulator[3:0]} + {1'b0, operand_i[3:0]}
                                      + 5'(cin);
                            res = sum[7:0];
                            next_r.accumulator = res;
                            next_r.cond_code_reg[CCR_BIT_H] = low_sum[4];
                            next_r.cond_code_reg[CCR_BIT_C] = sum[8];
                            next_r.cond_code_reg[CCR_BIT_V] =
                                (r.accumulator[7] == operand_i[7]) &&
                                (res[7] != r.accumulator[7]);
                        end
                        CCR_OP_SUB, CCR_OP_SBC: begin
                            cin = (op_i == CCR_OP_SBC) && r.cond_code_reg[CCR_BIT_C];
                            sum = {1'b0, r.accumulator} - {1'b0, operand_i} - 9'(cin);
                            res = sum[7:0];
                            next_r.accumulator = res;
                            next_r.cond_code_reg[CCR_BIT_C] = sum[8];
                            next_r.cond_code_reg[CCR_BIT_V] =
                                (r.accumulator[7] != operand_i[7]) &&
                                (res[7] != r.accumulator[7]);
                        end
                        CCR_OP_AND, CCR_OP_OR, CCR_OP_EOR, CCR_OP_LDA: begin
                            res = (op_i == CCR_OP_AND) ? (r.accumulator & operand_i) :
                                  (op_i == CCR_OP_OR)  ? (r.accumulator | operand_i) :
                                  (op_i == CCR_OP_EOR) ? (r.accumulator ^ operand_i) :
                                  operand_i;
                            next_r.accumulator = res;
                            next_r.cond_code_reg[CCR_BIT_V] = 1'b0;
                        end
                        CCR_OP_SHL, CCR_OP_ROL: begin
                            res = {r.accumulator[6:0],
                                   (op_i == CCR_OP_ROL) && r.cond_code_reg[CCR_BIT_C]};
                            next_r.accumulator = res;
                            next_r.cond_code_reg[CCR_BIT_C] = r.accumulator[7];
                            next_r.cond_code_reg[CCR_BIT_V] = res[7] ^ r.accumulator[7];
                        end
                        CCR_OP_SHR, CCR_OP_ROR: begin
                            res = {(op_i == CCR_OP_ROR) && r.cond_code_reg[CCR_BIT_C],
                                   r.accumulator[7:1]};
                            next_r.accumulator = res;
                            next_r.cond_code_reg[CCR_BIT_C] = r.accumulator[0];
                            next_r.cond_code_reg[CCR_BIT_V] = res[7] ^ r.accumulator[0];
                        end
                        CCR_OP_BTST: begin
                            // Bit number in the low operand bits, result kept out of N/Z
                            next_r.cond_code_reg[CCR_BIT_C] =
                                r.accumulator[operand_i[2:0]];
                        end
                        CCR_OP_RSP:
                            next_r.stack_ptr[7:0] = CCR_SP_LOW_RESET;
                        CCR_OP_CLI:
                            next_r.cond_code_reg[CCR_BIT_I] = 1'b0;
                        CCR_OP_SEI:
                            next_r.cond_code_reg[CCR_BIT_I] = 1'b1;
                        CCR_OP_SWI: begin
                            next_r.vec = CCR_VEC_SWI;
                            next_r.st = CCR_ST_PUSH;
                            next_r.step = 3'h0;
                        end
                        CCR_OP_RTI: begin
                            next_r.st = CCR_ST_PULL;
                            next_r.step = 3'h0;
                        end
                        CCR_OP_WAIT: begin
                            next_r.cond_code_reg[CCR_BIT_I] = 1'b0;
                            next_r.st = CCR_ST_WAIT;
                        end
                        CCR_OP_STOP: begin
                            if (stop_enable_i) begin
                                next_r.cond_code_reg[CCR_BIT_I] = 1'b0;
                                next_r.st = CCR_ST_STOP;
                            end else begin
                                next_r.vec = CCR_VEC_ILLEGAL;
                                next_r.st = CCR_ST_VEC_HI;
                            end
                        end
                        CCR_OP_PUSH_UPPER_INDEX_OP: begin
                            mem_addr_o = r.stack_ptr;
                            mem_wdata_o = r.index_pair[15:8];
                            mem_wr_o = 1'b1;
                            next_r.stack_ptr = 16'(r.stack_ptr - CCR_ONE16);
                        end
                        CCR_OP_PULL_UPPER_INDEX_OP: begin
                            // Decoder presents the pulled byte as operand
                            next_r.stack_ptr = 16'(r.stack_ptr + CCR_ONE16);
                            next_r.index_pair[15:8] = operand_i;
                        end
                        CCR_OP_JUMP:
                            next_r.prog_counter = target_i;
                        default: ;
                    endcase
                    if (op_i inside {CCR_OP_ADD, CCR_OP_ADC, CCR_OP_SUB, CCR_OP_SBC,
                            CCR_OP_AND, CCR_OP_OR, CCR_OP_EOR, CCR_OP_LDA, CCR_OP_SHL,
                            CCR_OP_SHR, CCR_OP_ROL, CCR_OP_ROR}) begin
                        next_r.cond_code_reg[CCR_BIT_N] = res[7];
                        next_r.cond_code_reg[CCR_BIT_Z] = (res == CCR_ZERO8);
                    end
                end
            end
            CCR_ST_PUSH: begin
                // PC low, PC high, X, A, CCR; upper index byte left off
                mem_wr_o = 1'b1;
                mem_addr_o = r.stack_ptr;
                unique case (r.step)
                    3'h0: mem_wdata_o = r.prog_counter[7:0];
                    3'h1: mem_wdata_o = r.prog_counter[15:8];
                    3'h2: mem_wdata_o = r.index_pair[7:0];
                    3'h3: mem_wdata_o = r.accumulator;
                    default: mem_wdata_o = r.cond_code_reg;
                endcase
                next_r.stack_ptr = 16'(r.stack_ptr - CCR_ONE16);
                next_r.step = 3'(r.step + 3'h1);
                if (r.step == 3'h4)
                    next_r.st = CCR_ST_MASK;
            end
            CCR_ST_MASK: begin
                next_r.cond_code_reg[CCR_BIT_I] = 1'b1;
                next_r.st = CCR_ST_IVEC_HI;
            end
            CCR_ST_IVEC_HI: begin
                mem_addr_o = r.vec;
                mem_rd_o = 1'b1;
                next_r.prog_counter[15:8] = mem_rdata_i;
                next_r.st = CCR_ST_IVEC_LO;
                next_r.step = 3'h0;
            end
            CCR_ST_IVEC_LO: begin
                // Read data is same-cycle, so both bytes land without a spare state
                mem_addr_o = 16'(r.vec + CCR_ONE16);
                mem_rd_o = 1'b1;
                next_r.prog_counter[7:0] = mem_rdata_i;
                next_r.st = CCR_ST_RUN;
            end
            CCR_ST_PULL: begin
                // Pull order is the reverse of the push
                mem_rd_o = 1'b1;
                mem_addr_o = 16'(r.stack_ptr + CCR_ONE16);
                next_r.stack_ptr = 16'(r.stack_ptr + CCR_ONE16);
                next_r.step = 3'(r.step + 3'h1);
                unique case (r.step)
                    3'h0: next_r.cond_code_reg = mem_rdata_i;
                    3'h1: next_r.accumulator = mem_rdata_i;
                    3'h2: next_r.index_pair[7:0] = mem_rdata_i;
                    3'h3: next_r.prog_counter[15:8] = mem_rdata_i;
                    default: next_r.prog_counter[7:0] = mem_rdata_i;
                endcase
                if (r.step == 3'h4) begin
                    next_r.st = CCR_ST_RUN;
                    next_r.step = 3'h0;
                    // Break stays on while its request is still raised
                    if (!r.misc_s2[3])
                        next_r.in_break = 1'b0;
                end
            end
            CCR_ST_RECOVER: begin
                // Counts synchronised reference edges, not core clocks
                if (r.osc_prev != r.misc_s2[4] && r.misc_s2[4]) begin
                    next_r.dly = CCR_DLY_W'(r.dly + CCR_DLY_W'(1));
                    if (stop_limit)
                        next_r.st = CCR_ST_RUN;
                end
            end
            CCR_ST_WAIT: begin
                if (irq_any || r.swi_pend)
                    next_r.st = CCR_ST_RUN;
            end
            CCR_ST_STOP: begin
                if (irq_any) begin
                    next_r.st = CCR_ST_RECOVER;
                    next_r.dly = '0;
                    next_r.step = 3'h0;
                end
            end
            default: next_r.st = CCR_ST_RUN;
        endcase

        if (reg_wr_i) begin
            unique case (reg_addr_i)
                CCR_ADDR_ACC: next_r.accumulator = reg_wdata_i[7:0];
                CCR_ADDR_IDX: next_r.index_pair = reg_wdata_i;
                CCR_ADDR_SP:  next_r.stack_ptr = reg_wdata_i;
                CCR_ADDR_PC:  next_r.prog_counter = reg_wdata_i;
                CCR_ADDR_CCR: next_r.cond_code_reg = reg_wdata_i[7:0];
                default: ;
            endcase
        end
        next_r.cond_code_reg = next_r.cond_code_reg | CCR_FIXED_ONES;
        unique case (reg_addr_i)
            CCR_ADDR_ACC:  next_r.rdata = {8'h00, r.accumulator};
            CCR_ADDR_IDX:  next_r.rdata = r.index_pair;
            CCR_ADDR_SP:   next_r.rdata = r.stack_ptr;
            CCR_ADDR_PC:   next_r.rdata = r.prog_counter;
            CCR_ADDR_CCR:  next_r.rdata = {8'h00, r.cond_code_reg};
            CCR_ADDR_STAT: next_r.rdata = {14'h0000, r.in_break, r.swi_pend};
            default:       next_r.rdata = 16'h0000;
        endcase
        if (!reg_rd_i)
            next_r.rdata = r.rdata;
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
            r.st <= CCR_ST_VEC_HI;
            r.stack_ptr <= CCR_SP_RESET;
            r.cond_code_reg <= CCR_CCR_RESET;
            r.vec <= CCR_VEC_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata_o = r.rdata;
    assign cpu_clock_run_o = !(r.st inside {CCR_ST_WAIT, CCR_ST_STOP, CCR_ST_RECOVER});
    assign in_break_o = r.in_break;
endmodule // ccr_core

// File: ccr_pkg.sv
// Package: constants and types for the CPU core register file
package ccr_pkg;
    localparam int          CCR_NUM_IRQ        = 8;
    localparam logic [15:0] CCR_SP_RESET       = 16'h00FF;
    localparam logic [7:0]  CCR_SP_LOW_RESET   = 8'hFF;
    localparam logic [15:0] CCR_VEC_RESET      = 16'hFFFE;
    localparam logic [15:0] CCR_VEC_SWI        = 16'hFFFC;
    localparam logic [15:0] CCR_VEC_SWI_MON    = 16'hFEFC;
    localparam logic [15:0] CCR_VEC_ILLEGAL    = 16'hFFFE;
    localparam logic [15:0] CCR_VEC_IRQ_BASE   = 16'hFFFA;
    localparam logic [15:0] CCR_VEC_IRQ_STEP   = 16'h0002;
    localparam logic [15:0] CCR_ONE16          = 16'h0001;
    localparam logic [7:0]  CCR_ONE8           = 8'h01;
    localparam logic [7:0]  CCR_ZERO8          = 8'h00;
    // Flag positions
    localparam int CCR_BIT_V = 7;
    localparam int CCR_BIT_1A = 6;
    localparam int CCR_BIT_1B = 5;
    localparam int CCR_BIT_H = 4;
    localparam int CCR_BIT_I = 3;
    localparam int CCR_BIT_N = 2;
    localparam int CCR_BIT_Z = 1;
    localparam int CCR_BIT_C = 0;
    localparam logic [7:0]  CCR_FIXED_ONES     = 8'h60;
    localparam logic [7:0]  CCR_CCR_RESET      = 8'h68;
    // Stop recovery, in oscillator reference cycles
    localparam int          CCR_STOP_SHORT_CYC = 32;
    localparam int          CCR_STOP_LONG_CYC  = 4096;
    localparam int          CCR_DLY_W          = 13;
    // Internal register selectors for the plain port
    localparam logic [2:0]  CCR_ADDR_ACC       = 3'h0;
    localparam logic [2:0]  CCR_ADDR_IDX       = 3'h1;
    localparam logic [2:0]  CCR_ADDR_SP        = 3'h2;
    localparam logic [2:0]  CCR_ADDR_PC        = 3'h3;
    localparam logic [2:0]  CCR_ADDR_CCR       = 3'h4;
    localparam logic [2:0]  CCR_ADDR_STAT      = 3'h5;
    // Core operation codes
    typedef enum logic [4:0] {
        CCR_OP_NONE, CCR_OP_ADD, CCR_OP_ADC, CCR_OP_SUB, CCR_OP_SBC,
        CCR_OP_AND, CCR_OP_OR, CCR_OP_EOR, CCR_OP_LDA, CCR_OP_SHL,
        CCR_OP_SHR, CCR_OP_ROL, CCR_OP_ROR, CCR_OP_BTST, CCR_OP_RSP,
        CCR_OP_CLI, CCR_OP_SEI, CCR_OP_SWI, CCR_OP_RTI, CCR_OP_WAIT,
        CCR_OP_STOP, CCR_OP_PUSH_UPPER_INDEX_OP, CCR_OP_PULL_UPPER_INDEX_OP, CCR_OP_JUMP
    } ccr_op_t;
    typedef enum {
        CCR_ST_RUN, CCR_ST_VEC_HI, CCR_ST_VEC_LO, CCR_ST_PUSH, CCR_ST_MASK,
        CCR_ST_IVEC_HI, CCR_ST_IVEC_LO, CCR_ST_PULL, CCR_ST_WAIT,
        CCR_ST_STOP, CCR_ST_RECOVER
    } ccr_state_t;
endpackage

// File: ccr_core_props.sv
// Checker: port-level properties of the CPU core register file
`timescale 1ns/10ps
module ccr_core_props
    import ccr_pkg::*;
(
    input wire logic        clock_i,
    input wire logic        rst_i,
    input wire logic        op_valid_i,
    input wire ccr_op_t     op_i,
    input wire logic        op_ready_o,
    input wire logic [15:0] mem_addr_o,
    input wire logic        mem_wr_o,
    input wire logic        mem_rd_o,
    input wire logic        stop_enable_i,
    input wire logic        cpu_clock_run_o,
    input wire logic [2:0]  reg_addr_i,
    input wire logic        reg_rd_i,
    input wire logic [15:0] reg_rdata_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    wire op_go = op_valid_i && op_ready_o;
    a_ccr_fixed_ones: assert property (
        reg_rd_i && reg_addr_i == CCR_ADDR_CCR |=> reg_rdata_o[6:5] == 2'b11)
        else $error("ccr fixed bits not one");
    a_reset_vec_fetch: assert property (
        $fell(rst_i) |-> mem_rd_o && mem_addr_o == CCR_VEC_RESET
        ##1 mem_rd_o && mem_addr_o == 16'hFFFF) else $error("reset vector fetch wrong");
    a_read_ascends: assert property (
        mem_rd_o && $past(mem_rd_o) && !$past(rst_i)
        |-> mem_addr_o == $past(mem_addr_o) + 16'h0001) else $error("read address skips");
    a_push_descends: assert property (
        mem_wr_o && $past(mem_wr_o) && !$past(rst_i)
        |-> mem_addr_o == $past(mem_addr_o) - 16'h0001) else $error("push address skips");
    a_push_mask_vec: assert property (
        mem_wr_o [*5] ##1 !mem_wr_o |-> !mem_rd_o ##1 mem_rd_o [*2])
        else $error("stack, mask, vector order broken");
    a_wait_halts: assert property (
        op_go && op_i == CCR_OP_WAIT |=> !cpu_clock_run_o) else $error("wait kept clock");
    a_stop_halts: assert property (
        op_go && op_i == CCR_OP_STOP && stop_enable_i |=> !cpu_clock_run_o)
        else $error("stop kept clock");
    a_stop_illegal: assert property (
        op_go && op_i == CCR_OP_STOP && !stop_enable_i |=> cpu_clock_run_o)
        else $error("disabled stop halted clock");
    c_stack_frame: cover property (mem_wr_o [*5]);
    c_wait: cover property (op_go && op_i == CCR_OP_WAIT);
    c_halt: cover property ($fell(cpu_clock_run_o));
endmodule // ccr_core_props

// File: ccr_mem_model.sv
// Partner: behavioural memory on the far side of the core bus
`timescale 1ns/10ps
module ccr_mem_model (
    // Clock
    input  wire logic        clock_i,
    // Bus from the core
    input  wire logic [15:0] mem_addr_i,
    input  wire logic [7:0]  mem_wdata_i,
    input  wire logic        mem_wr_i,
    input  wire logic        mem_rd_i,
    output logic [7:0]       mem_rdata_o
);
    logic [7:0] ram [0:65535];
    logic [7:0] last = 8'h00;
    initial begin
        for (int a = 0; a < 65536; a++) begin
            ram[a] = a[7:0] ^ a[15:8];
        end
    end
    // Idle cycles show the inverse of the last byte, never a stale copy
    assign mem_rdata_o = mem_rd_i ? ram[mem_addr_i] : ~last;
    always @(posedge clock_i) begin
        if (mem_rd_i) last <= ram[mem_addr_i];
        if (mem_wr_i) ram[mem_addr_i] <= mem_wdata_i;
    end
endmodule // ccr_mem_model

// File: cpu_core_registers_ccr_bench.sv
// Testbench: register-port and operation sequences for the CPU core
`timescale 1ns/10ps
module cpu_core_registers_ccr_bench;
    import ccr_pkg::*;
    logic        clock_i = 1'b0, rst_i = 1'b1, osc = 1'b0, stop_enable_i = 1'b0;
    logic        op_valid_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic        break_req_i = 1'b0, break_en_i = 1'b0, mon = 1'b0;
    ccr_op_t     op_i = CCR_OP_NONE;
    logic [7:0]  operand_i = 8'h00, irq_req_i = 8'h00, mem_wdata_o;
    logic [2:0]  reg_addr_i = 3'h0;
    logic [15:0] reg_wdata_i = 16'h0000, mem_addr_o, reg_rdata_o;
    logic        op_ready_o, mem_wr_o, mem_rd_o, cpu_clock_run_o, in_break_o;
    wire  [7:0]  mem_rdata_i;
    int          n_errors = 0, check_count = 0, n;
    always #2.5 clock_i = ~clock_i;
    always #7 osc = ~osc;
    ccr_core uut (.clock_i, .rst_i, .op_valid_i, .op_i, .operand_i, .target_i(16'h0000),
        .fetch_i(1'b0), .op_ready_o, .mem_addr_o, .mem_wdata_o, .mem_wr_o, .mem_rd_o,
        .mem_rdata_i, .irq_req_i, .break_req_i, .break_en_i, .monitor_mode_i(mon),
        .short_recovery_option_i(1'b1), .stop_enable_i, .oscillator_ref_clock_i(osc),
        .cpu_clock_run_o, .in_break_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o);
    ccr_mem_model mem (.clock_i, .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
        .mem_wr_i(mem_wr_o), .mem_rd_i(mem_rd_o), .mem_rdata_o(mem_rdata_i));
    task automatic check(input string what, input logic [15:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clock_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask
    // Mask lets one read judge a single flag
    task automatic rchk(input logic [2:0] a, input logic [15:0] m, e);
        @(posedge clock_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        @(negedge clock_i);
        check($sformatf("reg%0d", a), reg_rdata_o & m, e);
    endtask
    task automatic settle();
        repeat (4) @(negedge clock_i);
        for (n = 0; n < 30000 && !op_ready_o; n++) @(negedge clock_i);
    endtask
    // Request held until sampled with ready high
    task automatic op(input ccr_op_t o, input logic [7:0] v);
        @(posedge clock_i);
        op_valid_i <= 1'b1;
        op_i <= o;
        operand_i <= v;
        do @(negedge clock_i); while (!op_ready_o);
        @(posedge clock_i);
        op_valid_i <= 1'b0;
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #50000;
        n_errors++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge clock_i);
        rst_i <= 1'b0;
        settle();
        rchk(CCR_ADDR_SP, 16'hFFFF, 16'h00FF);
        rchk(CCR_ADDR_CCR, 16'h00FF, 16'h0068);
        rchk(CCR_ADDR_PC, 16'hFFFF, 16'h0100);
        wr(CCR_ADDR_ACC, 16'h000F);
        wr(3'h7, 16'h00AA);
        rchk(3'h7, 16'hFFFF, 16'h0000);
        op(CCR_OP_ADD, 8'h01);
        rchk(CCR_ADDR_ACC, 16'h00FF, 16'h0010);
        rchk(CCR_ADDR_CCR, 16'h00FF, 16'h0078);
        op(CCR_OP_ADD, 8'h70);
        rchk(CCR_ADDR_CCR, 16'h00FF, 16'h00EC);
        op(CCR_OP_ADD, 8'h80);
        rchk(CCR_ADDR_CCR, 16'h00FF, 16'h00EB);
        op(CCR_OP_SUB, 8'h01);
        rchk(CCR_ADDR_CCR, 16'h00FF, 16'h006D);
        wr(CCR_ADDR_SP, 16'h1234);
        op(CCR_OP_RSP, 8'h00);
        rchk(CCR_ADDR_SP, 16'hFFFF, 16'h12FF);
        wr(CCR_ADDR_IDX, 16'hAB12);
        op(CCR_OP_PUSH_UPPER_INDEX_OP, 8'h00);
        op(CCR_OP_PULL_UPPER_INDEX_OP, 8'hCD);
        check("pushed h", mem.ram[16'h12FF], 16'h00AB);
        rchk(CCR_ADDR_IDX, 16'hFFFF, 16'hCD12);
        wr(CCR_ADDR_ACC, 16'h0055);
        irq_req_i <= 8'h06;
        repeat (3) op(CCR_OP_NONE, 8'h00);
        rchk(CCR_ADDR_SP, 16'hFFFF, 16'h12FF);
        op(CCR_OP_CLI, 8'h00);
        op(CCR_OP_NONE, 8'h00);
        settle();
        irq_req_i <= 8'h00;
        rchk(CCR_ADDR_SP, 16'hFFFF, 16'h12FA);
        rchk(CCR_ADDR_PC, 16'hFFFF, 16'h0706);
        rchk(CCR_ADDR_CCR, 16'h0008, 16'h0008);
        check("stacked x", mem.ram[16'h12FD], 16'h0012);
        check("stacked ccr", mem.ram[16'h12FB], 16'h0065);
        op(CCR_OP_RTI, 8'h00);
        settle();
        rchk(CCR_ADDR_CCR, 16'h00FF, 16'h0065);
        rchk(CCR_ADDR_ACC, 16'h00FF, 16'h0055);
        // Break is taken at the next instruction boundary
        for (int m = 0; m < 2; m++) begin
            mon <= m[0];
            break_en_i <= 1'b1;
            break_req_i <= 1'b1;
            repeat (2) op(CCR_OP_NONE, 8'h00);
            settle();
            check("in break", in_break_o, 16'h0001);
            rchk(CCR_ADDR_PC, 16'hFFFF, m ? 16'h0203 : 16'h0302);
            break_req_i <= 1'b0;
            op(CCR_OP_RTI, 8'h00);
            settle();
            check("break over", in_break_o, 16'h0000);
        end
        op(CCR_OP_WAIT, 8'h00);
        @(negedge clock_i);
        check("wait clock", cpu_clock_run_o, 16'h0000);
        irq_req_i <= 8'h01;
        op(CCR_OP_NONE, 8'h00);
        settle();
        irq_req_i <= 8'h00;
        rchk(CCR_ADDR_PC, 16'hFFFF, 16'h0504);
        op(CCR_OP_RTI, 8'h00);
        stop_enable_i <= 1'b1;
        op(CCR_OP_STOP, 8'h00);
        irq_req_i <= 8'h01;
        @(negedge clock_i);
        for (n = 0; n < 30000 && !cpu_clock_run_o; n++) @(negedge clock_i);
        check("stop delay", n >= 89 && n <= 100, 16'h0001);
        settle();
        irq_req_i <= 8'h00;
        op(CCR_OP_RTI, 8'h00);
        stop_enable_i <= 1'b0;
        op(CCR_OP_STOP, 8'h00);
        settle();
        rchk(CCR_ADDR_PC, 16'hFFFF, 16'h0100);
        close_out();
    end
endmodule // cpu_core_registers_ccr_bench
bind ccr_core ccr_core_props chk (.clock_i, .rst_i, .op_valid_i, .op_i, .op_ready_o,
    .mem_addr_o, .mem_wr_o, .mem_rd_o, .stop_enable_i, .cpu_clock_run_o, .reg_addr_i,
    .reg_rd_i, .reg_rdata_o);
